/* hdl/swm_master.sv */
`timescale 1ns/100ps
module swm_master import swm_pkg::*; #(
  parameter int RST_LOW_N = RST_LOW_CYC,
  parameter int RST_HIGH_N = RST_HIGH_CYC,
  parameter int COPY_N = COPY_CYC,
  parameter int CONV_N = CONV_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Operation request
  input wire logic opStart,
  input wire logic [1:0] opCode,
  input wire logic [7:0] opData,
  input wire logic opPullup,
  input wire logic opLongPullup,
  // Operation answer
  output logic opReady,
  output logic opDone,
  output logic [7:0] rdData,
  output logic presence,
  output logic crcOk,
  output logic spuOn,
  // Data line, open drain
  input wire logic dqIn,
  output logic dqOut,
  output logic dqOe_n
);
  // Controller state
  swm_state_t state, next_state;
  logic [CW-1:0] cnt, next_cnt; // Cycle counter of current phase
  logic [1:0] mode, next_mode; // Latched operation
  logic [7:0] shReg, next_shReg; // Bit shifter, LSB out first
  logic [2:0] bitIdx, next_bitIdx; // Bit within byte
  logic spuReq, next_spuReq; // Pullup after this byte
  logic spuLong, next_spuLong; // Conversion length pullup
  logic [7:0] crc, next_crc; // Running check code of reads
  logic [7:0] next_rdData;
  logic next_presence, next_crcOk, next_opDone;
  logic [CW-1:0] lowLen; // Low time of current slot
  logic [CW-1:0] spuLen; // Pullup hold length
  logic rdSample; // Read sample strike
  logic rdBit; // Bit taken from line
  // Line synchroniser
  logic dqMeta, dqSync;
  // Helper run counters for checks
  logic [CW-1:0] lowRun, next_lowRun;
  logic [CW-1:0] highRun, next_highRun;

  // Two flops bring the line in
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dqMeta <= 1'b1;
      dqSync <= 1'b1;
    end else begin
      dqMeta <= dqIn;
      dqSync <= dqMeta;
    end
  end

  // Line drive, only low or released
  assign dqOut = 1'b0;
  assign dqOe_n = !(state == ST_RST_LOW || state == ST_SLOT_LOW);
  assign opReady = (state == ST_IDLE);
  assign spuOn = (state == ST_SPU);

  // Slot low time by kind of slot
  always_comb begin
    if (mode == OP_READ) begin
      lowLen = RD_LOW_CYC;
    end else if (shReg[0]) begin
      lowLen = W1_LOW_CYC;
    end else begin
      lowLen = W0_LOW_CYC;
    end
  end

  // Pullup length by command kind
  always_comb begin
    if (spuLong) begin
      spuLen = CW'(CONV_N);
    end else begin
      spuLen = CW'(COPY_N);
    end
  end

  // Late read sample, short init before it
  assign rdSample = (state == ST_SLOT_REST) && (mode == OP_READ)
    && (cnt == RD_SAMPLE_CYC);
  assign rdBit = dqSync;

  // Next state and data of the controller
  always_comb begin
    next_state = state;
    next_cnt = cnt + 24'h1;
    next_mode = mode;
    next_shReg = shReg;
    next_bitIdx = bitIdx;
    next_spuReq = spuReq;
    next_spuLong = spuLong;
    next_crc = crc;
    next_rdData = rdData;
    next_presence = presence;
    next_opDone = 1'b0;
    case (state)
      // Wait for a request
      ST_IDLE: begin
        next_cnt = '0;
        if (opStart) begin
          // Latch the whole request at once
          next_mode = opCode;
          next_shReg = opData;
          next_bitIdx = 3'h0;
          next_spuReq = opPullup && (opCode == OP_WRITE);
          next_spuLong = opLongPullup;
          if (opCode == OP_RESET) begin
            next_state = ST_RST_LOW;
          end else if (opCode == OP_WRITE || opCode == OP_READ) begin
            next_state = ST_SLOT_LOW;
          end else begin
            next_opDone = 1'b1; // Unknown code, finish at once
          end
        end
      end
      // Reset pulse held low
      ST_RST_LOW: begin
        if (cnt == CW'(RST_LOW_N - 1)) begin
          next_state = ST_RST_REL;
          next_cnt = '0;
        end
      end
      // Released, watch for presence
      ST_RST_REL: begin
        // One sample, late in the presence pulse
        if (cnt == PD_SAMPLE_CYC) begin
          next_presence = !dqSync;
        end
        if (cnt == CW'(RST_HIGH_N - 1)) begin
          next_state = ST_IDLE;
          next_crc = CRC_INIT;
          next_opDone = 1'b1;
        end
      end
      // Slot opens with line low
      ST_SLOT_LOW: begin
        if (cnt == lowLen - 24'h1) begin
          next_state = ST_SLOT_REST;
        end
      end
      // Rest of slot, line released
      ST_SLOT_REST: begin
        // Read bit enters from the top, check code follows
        if (rdSample) begin
          next_shReg = {rdBit, shReg[7:1]};
          if (crc[0] ^ rdBit) begin
            next_crc = (crc >> 1) ^ CRC_POLY;
          end else begin
            next_crc = crc >> 1;
          end
        end
        // Slot over, write shifter moves to next bit
        if (cnt == SLOT_CYC - 24'h1) begin
          next_state = ST_RECOVER;
          next_cnt = '0;
          if (mode == OP_WRITE) begin
            next_shReg = {1'b0, shReg[7:1]};
          end
        end
      end
      // Recovery between slots
      ST_RECOVER: begin
        if (cnt == REC_CYC - 24'h1) begin
          next_cnt = '0;
          // Next bit of this byte, or byte finished
          if (bitIdx != 3'h7) begin
            next_bitIdx = bitIdx + 3'h1;
            next_state = ST_SLOT_LOW;
          end else begin
            if (mode == OP_READ) begin
              next_rdData = shReg;
            end
            if (spuReq) begin
              next_state = ST_SPU;
            end else begin
              next_state = ST_IDLE;
              next_opDone = 1'b1;
            end
          end
        end
      end
      // Strong pullup, bus quiet
      ST_SPU: begin
        // Line left to the strong pullup for the whole hold
        if (cnt == spuLen - 24'h1) begin
          next_state = ST_IDLE;
          next_opDone = 1'b1;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_cnt = '0;
      end
    endcase
    next_crcOk = (next_crc == CRC_INIT);
  end

  // Register controller state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= ST_IDLE;
      cnt <= '0;
      mode <= OP_RESET;
      shReg <= BYTE_INIT;
      bitIdx <= 3'h0;
      spuReq <= 1'b0;
      spuLong <= 1'b0;
      crc <= CRC_INIT;
      rdData <= BYTE_INIT;
      presence <= 1'b0;
      crcOk <= 1'b1;
      opDone <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      mode <= next_mode;
      shReg <= next_shReg;
      bitIdx <= next_bitIdx;
      spuReq <= next_spuReq;
      spuLong <= next_spuLong;
      crc <= next_crc;
      rdData <= next_rdData;
      presence <= next_presence;
      crcOk <= next_crcOk;
      opDone <= next_opDone;
    end
  end

  // Run lengths of driven and released line
  always_comb begin
    next_lowRun = dqOe_n ? '0 : lowRun + 24'h1;
    next_highRun = highRun;
    if (!dqOe_n) begin
      next_highRun = '0;
    end else if (highRun != '1) begin
      next_highRun = highRun + 24'h1;
    end
  end

  // Register run lengths
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lowRun <= '0;
      highRun <= '1;
    end else begin
      lowRun <= next_lowRun;
      highRun <= next_highRun;
    end
  end

  // Protocol checks, one clock, quiet in reset
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  AST_RST_LOW: assert property (
    $rose(dqOe_n) && state == ST_RST_REL |-> lowRun >= CW'(RST_LOW_N))
    else $error("reset pulse too short");
  AST_W1_LOW: assert property (
    $rose(dqOe_n) && state == ST_SLOT_REST && mode == OP_WRITE
    && shReg[0] |-> lowRun >= 24'h1 && lowRun <= W1_MAX_CYC)
    else $error("write one low time out of range");
  AST_W0_LOW: assert property (
    $rose(dqOe_n) && state == ST_SLOT_REST && mode == OP_WRITE
    && !shReg[0] |-> lowRun >= SLOT_MIN_CYC)
    else $error("write zero low time too short");
  AST_RD_INIT: assert property (
    $rose(dqOe_n) && state == ST_SLOT_REST && mode == OP_READ
    |-> lowRun >= RD_LOW_CYC && lowRun < RDV_CYC)
    else $error("read slot opening wrong");
  AST_SLOT_LEN: assert property (
    state == ST_RECOVER && $past(state) == ST_SLOT_REST
    |-> $past(cnt) >= SLOT_MIN_CYC - 24'h1)
    else $error("slot shorter than minimum");
  AST_RECOVERY: assert property (
    $fell(dqOe_n) |-> highRun >= REC_MIN_CYC)
    else $error("recovery between slots too short");
  AST_SAMPLE: assert property (
    rdSample |-> cnt + 24'h2 < RDV_CYC && dqOe_n)
    else $error("read sample outside valid window");
  AST_SPU_QUIET: assert property (
    spuOn |-> dqOe_n)
    else $error("line driven during strong pullup");
  AST_SPU_SOON: assert property (
    $rose(spuOn) |-> $past(state) == ST_RECOVER
    && $past(cnt) < SPU_MAX_CYC)
    else $error("strong pullup late");
  AST_REC_GAP: assert property (
    state == ST_SLOT_LOW && $past(state) == ST_RECOVER
    |-> $past(cnt) >= REC_MIN_CYC - 24'h1)
    else $error("recovery before next slot too short");
  AST_RD_LATCH: assert property (
    opDone && $past(state) == ST_RECOVER && $past(mode) == OP_READ
    |-> rdData == $past(shReg))
    else $error("read byte not handed over");
  AST_PRES_HOLD: assert property (
    $changed(presence) |-> $past(state) == ST_RST_REL
    && $past(cnt) == PD_SAMPLE_CYC)
    else $error("presence changed outside its sample point");
endmodule

/* hdl/swm_pkg.sv */
// How it works
// - Master starts all signals except presence
// - Every transaction opens with reset, presence
// - Reset holds line low 480 us
// - One bit per write or read slot
// - Write slot 60 us, 1 us recovery
// - Every write slot starts pulling line low
// - Write one releases within 15 us
// - Write zero holds low whole slot; the code holds it 62 us of its 65 us slot
// - Read slots follow read scratchpad command
// - Read slots may poll reload status
// - Read slot 60 us, 1 us recovery
// - Read slot opens with 1 us low
// - Master samples read within 15 us
// - Short init and recovery, late sample
// - Convert sequence ends with strong pullup
// - Recheck scratchpad CRC, repeat on mismatch
// - Skip address then write three bytes
// - Copy command, strong pullup 10 ms
// - Bytes travel least significant bit first
// - Pullup within 10 us, bus quiet
package swm_pkg;
  // Clock period and counter width
  localparam int CLK_NS = 100;
  localparam int CW = 24;
  // Times as printed, in us or ms
  localparam int T_RST_LOW_US = 480;
  localparam int T_RST_HIGH_US = 480;
  localparam int T_PD_SAMPLE_US = 70;
  localparam int T_SLOT_US = 65;
  localparam int T_SLOT_MIN_US = 60;
  localparam int T_W0_LOW_US = 62;
  localparam int T_W1_LOW_US = 6;
  localparam int T_W1_MAX_US = 15;
  localparam int T_RD_LOW_US = 1;
  localparam int T_RD_SAMPLE_US = 13;
  localparam int T_RDV_US = 15;
  localparam int T_REC_US = 2;
  localparam int T_REC_MIN_US = 1;
  localparam int T_SPU_MAX_US = 10;
  localparam int T_COPY_MS = 10;
  localparam int T_CONV_MS = 750;
  // Long counts, handed to module parameters
  localparam int RST_LOW_CYC = (T_RST_LOW_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int RST_HIGH_CYC = (T_RST_HIGH_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int COPY_CYC = (T_COPY_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int CONV_CYC = (T_CONV_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  // Short counts in clock cycles
  localparam logic [CW-1:0] PD_SAMPLE_CYC = CW'((T_PD_SAMPLE_US * 1000
    + CLK_NS - 1) / CLK_NS);
  localparam logic [CW-1:0] SLOT_CYC = CW'((T_SLOT_US * 1000 + CLK_NS - 1)
    / CLK_NS);
  localparam logic [CW-1:0] SLOT_MIN_CYC = CW'((T_SLOT_MIN_US * 1000
    + CLK_NS - 1) / CLK_NS);
  localparam logic [CW-1:0] W0_LOW_CYC = CW'((T_W0_LOW_US * 1000
    + CLK_NS - 1) / CLK_NS);
  localparam logic [CW-1:0] W1_LOW_CYC = CW'((T_W1_LOW_US * 1000
    + CLK_NS - 1) / CLK_NS);
  localparam logic [CW-1:0] W1_MAX_CYC = CW'(T_W1_MAX_US * 1000 / CLK_NS);
  localparam logic [CW-1:0] RD_LOW_CYC = CW'((T_RD_LOW_US * 1000
    + CLK_NS - 1) / CLK_NS);
  localparam logic [CW-1:0] RD_SAMPLE_CYC = CW'(T_RD_SAMPLE_US * 1000
    / CLK_NS);
  localparam logic [CW-1:0] RDV_CYC = CW'(T_RDV_US * 1000 / CLK_NS);
  localparam logic [CW-1:0] REC_CYC = CW'((T_REC_US * 1000 + CLK_NS - 1)
    / CLK_NS);
  localparam logic [CW-1:0] REC_MIN_CYC = CW'((T_REC_MIN_US * 1000
    + CLK_NS - 1) / CLK_NS);
  localparam logic [CW-1:0] SPU_MAX_CYC = CW'(T_SPU_MAX_US * 1000 / CLK_NS);
  // Operation codes on the user port
  localparam logic [1:0] OP_RESET = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  // Command bytes the user sends through write operations
  localparam logic [7:0] CMD_MATCH_ADDR = 8'h55;
  localparam logic [7:0] CMD_SKIP_ADDR = 8'hCC;
  localparam logic [7:0] CMD_CONVERT = 8'h44;
  localparam logic [7:0] CMD_WRITE_PAD = 8'h4E;
  localparam logic [7:0] CMD_READ_PAD = 8'hBE;
  localparam logic [7:0] CMD_COPY_PAD = 8'h48;
  localparam logic [7:0] CMD_RELOAD_NONVOLATILE = 8'hB8;
  // Check code, reflected polynomial, and reset values
  localparam logic [7:0] CRC_POLY = 8'h8C;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] BYTE_INIT = 8'h00;
  // Controller states, one bit apart from slot low through slot rest to recovery
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RST_LOW = 3'h1,
    ST_RST_REL = 3'h3,
    ST_SLOT_LOW = 3'h2,
    ST_SLOT_REST = 3'h6,
    ST_RECOVER = 3'h7,
    ST_SPU = 3'h5
  } swm_state_t;
endpackage

/* test/swm_slave_model.sv */
`timescale 1ns/100ps
// Behavioural sensor: presence, write sampling, scratchpad readout
module swm_slave_model import swm_pkg::*; #(
  parameter int RST_DET = 700,
  parameter logic [63:0] PAD = 64'h0
) (
  // Clock and resolved line
  input wire logic clk_sys,
  input wire logic dq,
  input wire logic attached,
  // Line pull and observation
  output logic pullLow,
  output logic [7:0] rxByte,
  output logic [7:0] padCrc
);
  int lowCnt = 0;
  int pdCnt = 0;
  int slotCnt = 0;
  int txIdx = 0;
  int rxCnt = 0;
  int nByte = 0;
  logic prevDq = 1'b1;
  logic drv = 1'b0;
  logic sending = 1'b0;
  logic [7:0] rxSh = 8'h00;
  logic [7:0] rxB = 8'h00;
  logic [71:0] txBits;

  // Check byte over the first eight bytes, reflected form
  function automatic logic [7:0] crc_of(input logic [63:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 64; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
    return c;
  endfunction

  assign padCrc = crc_of(PAD);
  assign txBits = {padCrc, PAD};
  assign pullLow = drv;
  assign rxByte = rxB;

  // Line watcher, one decision per clock
  always @(posedge clk_sys) begin
    prevDq <= dq;
    lowCnt <= dq ? 0 : lowCnt + 1;
    if (rxCnt == 8) begin
      rxB <= rxSh;
      rxCnt <= 0;
      nByte <= nByte + 1;
      // Answer only after skip address, then read scratchpad
      if (nByte == 1 && rxB == CMD_SKIP_ADDR && rxSh == CMD_READ_PAD) begin
        sending <= 1'b1;
      end
    end
    if (dq && !prevDq && lowCnt >= RST_DET) begin
      pdCnt <= attached ? 1 : 0;
      slotCnt <= 0;
      rxCnt <= 0;
      nByte <= 0;
      txIdx <= 0;
      sending <= 1'b0;
    end else if (pdCnt > 0) begin
      // Wait 15 us, then hold low 60 us
      pdCnt <= (pdCnt == 750) ? 0 : pdCnt + 1;
      drv <= pdCnt >= 150 && pdCnt < 750;
    end else if (!dq && prevDq) begin
      slotCnt <= 1;
      if (sending) begin
        drv <= !txBits[txIdx];
        txIdx <= txIdx + 1;
        sending <= txIdx < 71;
      end
    end else if (slotCnt > 0) begin
      slotCnt <= slotCnt + 1;
      if (slotCnt == 150) drv <= 1'b0;
      if (slotCnt == 150 && !sending) begin
        rxSh <= {dq, rxSh[7:1]};
        rxCnt <= rxCnt + 1;
      end
    end
  end
endmodule

/* test/single_wire_slot_signaling_tb_top.sv */
`timescale 1ns/100ps
module single_wire_slot_signaling_tb_top import swm_pkg::*;;
  typedef struct {
    logic [1:0] code;
    logic [7:0] data;
    logic [7:0] want;
  } swm_row_t;
  localparam logic [63:0] PAD = 64'h3C5A_A5C3_8001_7EFF;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic opStart = 1'b0;
  logic [1:0] opCode = 2'h0;
  logic [7:0] opData = 8'h00;
  logic opPullup = 1'b0;
  logic opLong = 1'b0;
  logic attached = 1'b0;
  logic opReady, opDone, presence, crcOk, spuOn, dqOut, dqOe_n, pullLow, dq;
  logic [7:0] rdData, rxByte, padCrc;
  int bad_count = 0;
  int num_checks = 0;
  int lowMax, lowMin, perMin, spuCnt, oeInSpu;
  swm_row_t rows[11];

  // Clock and open-drain line with pullup
  always #50 clk_sys = ~clk_sys;
  assign dq = !((!dqOe_n && !dqOut) || pullLow);

  swm_master #(.RST_LOW_N(800), .RST_HIGH_N(800), .COPY_N(50),
    .CONV_N(80)) uut (.clk_sys(clk_sys), .srst(srst), .opStart(opStart),
    .opCode(opCode), .opData(opData), .opPullup(opPullup),
    .opLongPullup(opLong), .opReady(opReady), .opDone(opDone),
    .rdData(rdData), .presence(presence), .crcOk(crcOk), .spuOn(spuOn),
    .dqIn(dq), .dqOut(dqOut), .dqOe_n(dqOe_n));
  swm_slave_model #(.RST_DET(700), .PAD(PAD)) slave (.clk_sys(clk_sys),
    .dq(dq), .attached(attached), .pullLow(pullLow), .rxByte(rxByte),
    .padCrc(padCrc));

  // Verdict and end of run
  task automatic close_out();
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One operation, measuring master low runs and pullup meanwhile
  task automatic run_op(input logic [1:0] c, input logic [7:0] d,
    input logic p);
    int n;
    int run;
    int last;
    n = 0;
    run = 0;
    last = -1;
    lowMax = 0;
    lowMin = 99999;
    perMin = 99999;
    spuCnt = 0;
    oeInSpu = 0;
    @(negedge clk_sys);
    opStart = 1'b1;
    opCode = c;
    opData = d;
    opPullup = p;
    while (opDone !== 1'b1) begin
      @(negedge clk_sys);
      n++;
      // A second request while busy must be ignored
      opStart = (n == 5);
      if (n == 5) check(8'(opReady), 8'h00);
      if (dqOe_n === 1'b0) begin
        if (run == 0 && last >= 0 && n - last < perMin) perMin = n - last;
        if (run == 0) last = n;
        run++;
      end else if (run > 0) begin
        lowMax = run > lowMax ? run : lowMax;
        lowMin = run < lowMin ? run : lowMin;
        run = 0;
      end
      if (spuOn === 1'b1) spuCnt++;
      if (spuOn === 1'b1 && dqOe_n !== 1'b1) oeInSpu++;
      if (n > 20000) begin
        bad_count++;
        $display("Error at %0t: no completion", $time);
        close_out();
      end
    end
  endtask

  // Main sequence
  initial begin
    repeat (16) @(negedge clk_sys);
    srst = 1'b0;
    @(negedge clk_sys);
    check({opReady, opDone, presence, crcOk, spuOn, dqOe_n, 2'h0},
      8'h94);
    check(rdData, 8'h00);
    run_op(OP_RESET, 8'h00, 1'b0);
    check(8'(presence), 8'h00);
    attached = 1'b1;
    run_op(OP_RESET, 8'h00, 1'b0);
    check(8'(presence), 8'h01);
    check(8'(lowMax >= 800), 8'h01);
    rows[0] = '{OP_WRITE, CMD_SKIP_ADDR, CMD_SKIP_ADDR};
    rows[1] = '{OP_WRITE, CMD_READ_PAD, CMD_READ_PAD};
    for (int i = 0; i < 9; i++) begin
      rows[i + 2] = '{OP_READ, 8'h00, i < 8 ? PAD[8 * i +: 8] : padCrc};
    end
    foreach (rows[i]) begin
      logic wr;
      wr = rows[i].code == OP_WRITE;
      run_op(rows[i].code, rows[i].data, 1'b0);
      if (wr) check(rxByte, rows[i].want);
      else check(rdData, rows[i].want);
      if (i == 2) check(8'(crcOk), 8'h00);
      check(8'(perMin >= 610 && lowMin >= 10), 8'h01);
      if (wr) check(8'(lowMax >= 600 && lowMin <= 150), 8'h01);
      else check(8'(lowMax < 150), 8'h01);
    end
    check(8'(crcOk), 8'h01);
    run_op(OP_RESET, 8'h00, 1'b0);
    run_op(OP_WRITE, CMD_SKIP_ADDR, 1'b0);
    opLong = 1'b1;
    run_op(OP_WRITE, CMD_CONVERT, 1'b1);
    check(8'(spuCnt >= 80), 8'h01);
    opLong = 1'b0;
    run_op(OP_WRITE, CMD_COPY_PAD, 1'b1);
    check(8'(spuCnt >= 50 && spuCnt < 80), 8'h01);
    check(8'(oeInSpu), 8'h00);
    check(8'(spuOn), 8'h00);
    // Reset in mid-slot abandons the byte and releases the line
    @(negedge clk_sys);
    opStart = 1'b1;
    opCode = OP_WRITE;
    opData = 8'h00;
    @(negedge clk_sys);
    opStart = 1'b0;
    repeat (100) @(negedge clk_sys);
    check(8'(dqOe_n), 8'h00);
    srst = 1'b1;
    repeat (16) @(negedge clk_sys);
    srst = 1'b0;
    @(negedge clk_sys);
    check({opReady, opDone, presence, crcOk, spuOn, dqOe_n, dqOut, 1'b0},
      8'h94);
    run_op(OP_RESET, 8'h00, 1'b0);
    check(8'(presence), 8'h01);
    close_out();
  end
endmodule
